// [pkg/tlms_pkg.sv]
// register map, field layout, reset values and mode codes of the torque limit and mode select block
package tlms_pkg;
  localparam int ADDR_W = 6;
  localparam logic [5:0] OFS_CTRL = 6'h00;
  localparam logic [5:0] OFS_FWD_INT = 6'h04;
  localparam logic [5:0] OFS_REV_INT = 6'h08;
  localparam logic [5:0] OFS_POS_EXT = 6'h0c;
  localparam logic [5:0] OFS_NEG_EXT = 6'h10;
  localparam logic [5:0] OFS_TREF_GAIN = 6'h14;
  localparam logic [5:0] OFS_IN_ASSIGN = 6'h18;
  localparam logic [5:0] OFS_OUT_ASSIGN = 6'h1c;
  localparam logic [5:0] OFS_STATUS = 6'h20;
  localparam logic [5:0] OFS_INT_STAT = 6'h24;
  localparam logic [5:0] OFS_INT_MASK = 6'h28;
  // control register fields
  localparam int CTRL_CODE_LSB = 0;
  localparam int CTRL_DUAL_BIT = 4;
  localparam int CTRL_ANALOG_BIT = 5;
  // input assignment fields
  localparam int INA_POS_LSB = 0;
  localparam int INA_POS_EN_BIT = 3;
  localparam int INA_NEG_LSB = 4;
  localparam int INA_NEG_EN_BIT = 7;
  // output assignment fields
  localparam int OUTA_LSB = 0;
  localparam int OUTA_EN_BIT = 3;
  // status fields
  localparam int ST_MODE_LSB = 0;
  localparam int ST_POS_ON_BIT = 3;
  localparam int ST_NEG_ON_BIT = 4;
  localparam int ST_CLAMP_BIT = 5;
  localparam int ST_SPD_LSB = 6;
  // interrupt bits
  localparam int IRQ_CLAMP_BIT = 0;
  localparam int IRQ_MODE_BIT = 1;
  localparam int IRQ_W = 2;
  // reset values
  localparam logic [3:0] RST_CODE = 4'h0;
  localparam logic [15:0] RST_INT_LIM = 16'h012c;
  localparam logic [15:0] RST_EXT_LIM = 16'h0064;
  localparam logic [15:0] RST_GAIN = 16'h0100;
  localparam int GAIN_FRAC = 8;
  // terminals
  localparam int TERM_N = 8;
  localparam logic [2:0] DEF_POS_TERM = 3'h0;
  localparam logic [2:0] DEF_NEG_TERM = 3'h1;
  // mode combination codes
  localparam logic [3:0] CODE_ISPD_SPD = 4'h4;
  localparam logic [3:0] CODE_ISPD_POS = 4'h5;
  localparam logic [3:0] CODE_ISPD_TRQ = 4'h6;
  localparam logic [3:0] CODE_POS_SPD = 4'h7;
  localparam logic [3:0] CODE_POS_TRQ = 4'h8;
  localparam logic [3:0] CODE_TRQ_SPD = 4'h9;
  localparam logic [3:0] CODE_SPD_ZCL = 4'ha;
  localparam logic [3:0] CODE_POS_INH = 4'hb;
  typedef enum logic [2:0] {
    TLMS_SPEED = 3'h0,
    TLMS_POSITION = 3'h1,
    TLMS_TORQUE = 3'h2,
    TLMS_INT_SPEED = 3'h3,
    TLMS_ZERO_CLAMP = 3'h4,
    TLMS_POS_INHIBIT = 3'h5
  } tlms_mode_t;
endpackage

// [hdl/tlms_core.sv]
// torque limit selection, limiting status output and control mode selection with avalon registers
// Contract
// - pos input on: min forward internal, positive external
// - pos input off: forward internal limit only
// - neg input on: min reverse internal, negative external
// - neg input off: reverse internal limit only
// - single axis default terminals unless assigned; dual needs assignment
// - shared terminal drives every signal assigned
// - status output low while torque held at limit
// - status output only on assigned terminal
// - torque reference scaled by input gain
// - codes 4,5,6 pair internal speed with others
// - codes 7,8 pair position with speed, torque
// - code 9 pairs torque with speed
// - code A pairs speed with zero clamp
// - code B pairs position with pulse inhibit
// - codes 4-6: limit inputs become mode shift
// - analog limit plus external: smaller value wins
// - codes 7-B: proportional input selects mode
`timescale 1ns/1ps
module tlms_core
  import tlms_pkg::*;
(
  // clock and reset
  input wire logic core_clk,
  input wire logic rst,
  // avalon-mm slave
  input wire logic [tlms_pkg::ADDR_W-1:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  // interrupt
  output logic irq,
  // discrete terminals, active low
  input wire logic [tlms_pkg::TERM_N-1:0] term_in_n,
  input wire logic proportional_ctrl_in_n,
  output logic [tlms_pkg::TERM_N-1:0] term_out_n,
  // torque path, percent units
  input wire logic signed [15:0] torque_ref_in,
  input wire logic signed [15:0] torque_demand,
  output logic signed [15:0] torque_out,
  // mode result
  output tlms_pkg::tlms_mode_t active_mode,
  output logic [1:0] int_speed_sel,
  output logic pos_limit_alias,
  output logic neg_limit_alias,
  output logic torque_limiting_out_n
);
  import tlms_pkg::*;

  logic [3:0] mode_code;
  logic dual_axis;
  logic analog_lim_en;
  logic [15:0] fwd_internal_limit;
  logic [15:0] rev_internal_limit;
  logic [15:0] pos_external_limit;
  logic [15:0] neg_external_limit;
  logic [15:0] tref_gain;
  logic [7:0] in_assign;
  logic [3:0] out_assign;
  logic [IRQ_W-1:0] int_stat;
  logic [IRQ_W-1:0] int_mask;
  logic ack;
  logic wr_en;
  logic clamping;
  logic clamp_d;
  tlms_mode_t mode_d;
  logic pos_limit_in_n;
  logic neg_limit_in_n;
  logic shift_codes;
  logic pair_codes;
  tlms_mode_t next_mode;
  logic [1:0] next_spd;
  logic signed [15:0] tref_scaled;
  logic [15:0] analog_lim;
  logic [15:0] pos_lim;
  logic [15:0] neg_lim;
  logic signed [15:0] torque_src;
  logic signed [15:0] next_torque;
  logic next_clamp;
  logic [31:0] rd_mux;

  // byte-lane merge for register writes
  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] wd,
                                        input logic [3:0] be);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++) begin
      if (be[i]) begin
        r[i*8 +: 8] = wd[i*8 +: 8];
      end
    end
    return r;
  endfunction

  function automatic logic [15:0] umin(input logic [15:0] a, input logic [15:0] b);
    return (a < b) ? a : b;
  endfunction

  // pick one terminal for a logical input; off when not routed
  function automatic logic route_in(input logic [TERM_N-1:0] pins, input logic [2:0] sel,
                                    input logic en);
    return en ? pins[sel] : 1'b1;
  endfunction

  // gain is unsigned fixed point; result saturates to 16 bits
  function automatic logic signed [15:0] scale(input logic signed [15:0] v,
                                               input logic [15:0] g);
    logic signed [32:0] p;
    logic signed [24:0] s;
    p = v * $signed({1'b0, g});
    s = p[32:GAIN_FRAC];
    if (s > 25'sh0007fff) begin
      return 16'sh7fff;
    end else if (s < -25'sh0008000) begin
      return -16'sh8000;
    end
    return s[15:0];
  endfunction

  function automatic logic [15:0] absval(input logic signed [15:0] v);
    if (v == -16'sh8000) begin
      return 16'h7fff;
    end
    return v[15] ? 16'(-v) : 16'(v);
  endfunction

  // ---------------- bus slave ----------------
  // one wait cycle per access; the answer stands while waitrequest is low
  assign avs_waitrequest = (avs_read | avs_write) & ~ack;
  assign wr_en = avs_write & ack;

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      ack <= 1'b0;
    end else begin
      ack <= (avs_read | avs_write) & ~ack;
    end
  end

  always_comb begin
    rd_mux = 32'h0000_0000;
    unique case (avs_address)
      OFS_CTRL: begin
        rd_mux[CTRL_CODE_LSB +: 4] = mode_code;
        rd_mux[CTRL_DUAL_BIT] = dual_axis;
        rd_mux[CTRL_ANALOG_BIT] = analog_lim_en;
      end
      OFS_FWD_INT: rd_mux[15:0] = fwd_internal_limit;
      OFS_REV_INT: rd_mux[15:0] = rev_internal_limit;
      OFS_POS_EXT: rd_mux[15:0] = pos_external_limit;
      OFS_NEG_EXT: rd_mux[15:0] = neg_external_limit;
      OFS_TREF_GAIN: rd_mux[15:0] = tref_gain;
      OFS_IN_ASSIGN: rd_mux[7:0] = in_assign;
      OFS_OUT_ASSIGN: rd_mux[3:0] = out_assign;
      OFS_STATUS: begin
        rd_mux[ST_MODE_LSB +: 3] = active_mode;
        rd_mux[ST_POS_ON_BIT] = ~pos_limit_in_n;
        rd_mux[ST_NEG_ON_BIT] = ~neg_limit_in_n;
        rd_mux[ST_CLAMP_BIT] = clamping;
        rd_mux[ST_SPD_LSB +: 2] = int_speed_sel;
      end
      OFS_INT_STAT: rd_mux[IRQ_W-1:0] = int_stat;
      OFS_INT_MASK: rd_mux[IRQ_W-1:0] = int_mask;
      default: rd_mux = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      avs_readdata <= 32'h0000_0000;
    end else if (avs_read & ~ack) begin
      avs_readdata <= rd_mux;
    end
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      mode_code <= RST_CODE;
      dual_axis <= 1'b0;
      analog_lim_en <= 1'b0;
      in_assign <= 8'h00;
      out_assign <= 4'h0;
    end else if (wr_en) begin
      unique case (avs_address)
        OFS_CTRL: begin
          mode_code <= 4'(merge({26'h0, analog_lim_en, dual_axis, mode_code}, avs_writedata,
                                avs_byteenable) >> CTRL_CODE_LSB);
          dual_axis <= avs_byteenable[0] ? avs_writedata[CTRL_DUAL_BIT] : dual_axis;
          analog_lim_en <= avs_byteenable[0] ? avs_writedata[CTRL_ANALOG_BIT] : analog_lim_en;
        end
        OFS_IN_ASSIGN: in_assign <= avs_byteenable[0] ? avs_writedata[7:0] : in_assign;
        OFS_OUT_ASSIGN: out_assign <= avs_byteenable[0] ? avs_writedata[3:0] : out_assign;
        default: ;
      endcase
    end
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      fwd_internal_limit <= RST_INT_LIM;
      rev_internal_limit <= RST_INT_LIM;
      pos_external_limit <= RST_EXT_LIM;
      neg_external_limit <= RST_EXT_LIM;
      tref_gain <= RST_GAIN;
    end else if (wr_en) begin
      unique case (avs_address)
        OFS_FWD_INT: fwd_internal_limit <= 16'(merge({16'h0, fwd_internal_limit}, avs_writedata,
                                                     avs_byteenable));
        OFS_REV_INT: rev_internal_limit <= 16'(merge({16'h0, rev_internal_limit}, avs_writedata,
                                                     avs_byteenable));
        OFS_POS_EXT: pos_external_limit <= 16'(merge({16'h0, pos_external_limit}, avs_writedata,
                                                     avs_byteenable));
        OFS_NEG_EXT: neg_external_limit <= 16'(merge({16'h0, neg_external_limit}, avs_writedata,
                                                     avs_byteenable));
        OFS_TREF_GAIN: tref_gain <= 16'(merge({16'h0, tref_gain}, avs_writedata,
                                              avs_byteenable));
        default: ;
      endcase
    end
  end

  // ---------------- interrupts ----------------
  // a new event in the clearing cycle survives the clear
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      int_stat <= '0;
    end else begin
      int_stat <= (int_stat & ~((wr_en && avs_address == OFS_INT_STAT && avs_byteenable[0])
                                ? avs_writedata[IRQ_W-1:0] : '0))
                | {(active_mode != mode_d), (clamping & ~clamp_d)};
    end
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      int_mask <= '0;
    end else if (wr_en && avs_address == OFS_INT_MASK && avs_byteenable[0]) begin
      int_mask <= avs_writedata[IRQ_W-1:0];
    end
  end

  assign irq = |(int_stat & int_mask);

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      clamp_d <= 1'b0;
      mode_d <= TLMS_SPEED;
    end else begin
      clamp_d <= clamping;
      mode_d <= active_mode;
    end
  end

  // ---------------- input routing ----------------
  // each logical input indexes the terminal vector on its own, so one low
  // terminal asserts every signal routed to it
  always_comb begin
    if (dual_axis) begin
      pos_limit_in_n = route_in(term_in_n, in_assign[INA_POS_LSB +: 3],
                                in_assign[INA_POS_EN_BIT]);
      neg_limit_in_n = route_in(term_in_n, in_assign[INA_NEG_LSB +: 3],
                                in_assign[INA_NEG_EN_BIT]);
    end else begin
      pos_limit_in_n = in_assign[INA_POS_EN_BIT] ? term_in_n[in_assign[INA_POS_LSB +: 3]]
                                                 : term_in_n[DEF_POS_TERM];
      neg_limit_in_n = in_assign[INA_NEG_EN_BIT] ? term_in_n[in_assign[INA_NEG_LSB +: 3]]
                                                 : term_in_n[DEF_NEG_TERM];
    end
  end

  // ---------------- mode selection ----------------
  assign shift_codes = (mode_code == CODE_ISPD_SPD) || (mode_code == CODE_ISPD_POS)
                     || (mode_code == CODE_ISPD_TRQ);
  assign pair_codes = (mode_code >= CODE_POS_SPD) && (mode_code <= CODE_POS_INH);

  always_comb begin
    next_mode = TLMS_SPEED;
    next_spd = 2'h0;
    if (shift_codes) begin
      if (pos_limit_in_n & neg_limit_in_n) begin
        unique case (mode_code)
          CODE_ISPD_SPD: next_mode = TLMS_SPEED;
          CODE_ISPD_POS: next_mode = TLMS_POSITION;
          default: next_mode = TLMS_TORQUE;
        endcase
      end else begin
        next_mode = TLMS_INT_SPEED;
        next_spd = {~neg_limit_in_n, ~pos_limit_in_n};
      end
    end else if (pair_codes) begin
      unique case (mode_code)
        // input on (low) picks the second mode of each pair, off picks the first
        CODE_POS_SPD: next_mode = proportional_ctrl_in_n ? TLMS_POSITION
                                                         : TLMS_SPEED;
        CODE_POS_TRQ: next_mode = proportional_ctrl_in_n ? TLMS_POSITION
                                                         : TLMS_TORQUE;
        CODE_TRQ_SPD: next_mode = proportional_ctrl_in_n ? TLMS_TORQUE
                                                         : TLMS_SPEED;
        CODE_SPD_ZCL: next_mode = proportional_ctrl_in_n ? TLMS_SPEED
                                                         : TLMS_ZERO_CLAMP;
        default: next_mode = proportional_ctrl_in_n ? TLMS_POSITION
                                                    : TLMS_POS_INHIBIT;
      endcase
    end
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      active_mode <= TLMS_SPEED;
      int_speed_sel <= 2'h0;
    end else begin
      active_mode <= next_mode;
      int_speed_sel <= next_spd;
    end
  end

  // ---------------- torque limits ----------------
  // the analog limit only exists outside torque mode, since the reference
  // terminal then carries the torque command instead
  assign tref_scaled = scale(torque_ref_in, tref_gain);
  assign analog_lim = absval(tref_scaled);

  always_comb begin
    pos_lim = fwd_internal_limit;
    neg_lim = rev_internal_limit;
    if (!shift_codes && !pos_limit_in_n) begin
      pos_lim = umin(fwd_internal_limit, pos_external_limit);
    end
    if (!shift_codes && !neg_limit_in_n) begin
      neg_lim = umin(rev_internal_limit, neg_external_limit);
    end
    if (analog_lim_en && active_mode != TLMS_TORQUE) begin
      pos_lim = umin(pos_lim, analog_lim);
      neg_lim = umin(neg_lim, analog_lim);
    end
  end

  assign torque_src = (active_mode == TLMS_TORQUE) ? tref_scaled : torque_demand;

  always_comb begin
    next_torque = torque_src;
    next_clamp = 1'b0;
    // sign first: a negative demand must never compare as a large positive one
    if (!torque_src[15] && ($unsigned(torque_src) > pos_lim)) begin
      next_torque = 16'(pos_lim);
      next_clamp = 1'b1;
    end else if (torque_src[15] && (17'(absval(torque_src)) > {1'b0, neg_lim})) begin
      next_torque = 16'(-$signed({1'b0, neg_lim[14:0]}));
      next_clamp = 1'b1;
    end
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      torque_out <= 16'sh0000;
      clamping <= 1'b0;
    end else begin
      torque_out <= next_torque;
      clamping <= next_clamp;
    end
  end

  // ---------------- outputs ----------------
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      torque_limiting_out_n <= 1'b1;
      term_out_n <= '1;
      pos_limit_alias <= 1'b0;
      neg_limit_alias <= 1'b0;
    end else begin
      torque_limiting_out_n <= ~next_clamp;
      for (int i = 0; i < TERM_N; i++) begin
        term_out_n[i] <= ~(next_clamp && out_assign[OUTA_EN_BIT]
                           && out_assign[OUTA_LSB +: 3] == 3'(i));
      end
      pos_limit_alias <= ~shift_codes & ~pos_limit_in_n;
      neg_limit_alias <= ~shift_codes & ~neg_limit_in_n;
    end
  end
endmodule // tlms_core

// [tb/tlms_core_sva.sv]
// port assertions for the torque limit and mode select block
`timescale 1ns/1ps
module tlms_core_sva (
  // clock and reset
  input wire logic core_clk,
  input wire logic rst,
  // register bus
  input wire logic [tlms_pkg::ADDR_W-1:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_readdata,
  input wire logic avs_waitrequest,
  // torque path and status
  input wire logic signed [15:0] torque_demand,
  input wire logic signed [15:0] torque_out,
  input tlms_pkg::tlms_mode_t active_mode,
  input wire logic [1:0] int_speed_sel,
  input wire logic pos_limit_alias,
  input wire logic neg_limit_alias,
  input wire logic torque_limiting_out_n,
  input wire logic [tlms_pkg::TERM_N-1:0] term_out_n
);
  import tlms_pkg::*;
  default clocking @(posedge core_clk); endclocking
  default disable iff (rst);
  sequence s_wait; avs_waitrequest; endsequence
  sequence s_ack; !avs_waitrequest; endsequence
  a_bus_ack: assert property ($rose(avs_read || avs_write) |-> s_wait ##1 s_ack)
    else $error("bus access not answered on its second cycle");
  a_unmapped_zero: assert property (avs_read && !avs_waitrequest && avs_address > 6'h28
    |-> avs_readdata == 32'h0) else $error("unmapped read not zero");
  a_clamp_flag: assert property ($past(active_mode) != TLMS_TORQUE
    && torque_out != $past(torque_demand) |-> !torque_limiting_out_n)
    else $error("torque changed without limiting status");
  a_term_idle: assert property (torque_limiting_out_n |-> term_out_n == 8'hff)
    else $error("output terminal active without limiting");
  a_shift_alias: assert property (active_mode == TLMS_INT_SPEED
    |-> !pos_limit_alias && !neg_limit_alias) else $error("limit alias during shift codes");
  a_sel_zero: assert property (active_mode != TLMS_INT_SPEED |-> int_speed_sel == 2'h0)
    else $error("speed select outside internal speed");
  a_pos_keep: assert property ($past(active_mode) != TLMS_TORQUE
    && $past(torque_demand) >= 0 |-> torque_out >= 0 && torque_out <= $past(torque_demand))
    else $error("positive torque grew or flipped");
  a_neg_keep: assert property ($past(active_mode) != TLMS_TORQUE
    && $past(torque_demand) < 0 |-> torque_out <= 0 && torque_out >= $past(torque_demand))
    else $error("negative torque grew or flipped");
  a_mode_legal: assert property (active_mode <= TLMS_POS_INHIBIT)
    else $error("illegal mode value");
endmodule // tlms_core_sva

bind tlms_core tlms_core_sva u_sva (.core_clk(core_clk), .rst(rst), .avs_address(avs_address),
  .avs_read(avs_read), .avs_write(avs_write), .avs_readdata(avs_readdata),
  .avs_waitrequest(avs_waitrequest), .torque_demand(torque_demand), .torque_out(torque_out),
  .active_mode(active_mode), .int_speed_sel(int_speed_sel), .pos_limit_alias(pos_limit_alias),
  .neg_limit_alias(neg_limit_alias), .torque_limiting_out_n(torque_limiting_out_n),
  .term_out_n(term_out_n));

// [tb/tlms_host_model.sv]
// host controller model driving the discrete input terminals
`timescale 1ns/1ps
module tlms_host_model (
  // clock
  input wire logic core_clk,
  // commands from the bench
  input wire logic pos_on,
  input wire logic neg_on,
  input wire logic prop_on,
  input wire logic [2:0] pos_term,
  input wire logic [2:0] neg_term,
  // terminals, active low
  output logic [tlms_pkg::TERM_N-1:0] term_in_n,
  output logic proportional_ctrl_in_n
);
  import tlms_pkg::*;
  // only the limit signals sit on their terminals; a shared terminal ORs them
  always @(posedge core_clk) begin
    term_in_n <= ~((8'(pos_on) << pos_term) | (8'(neg_on) << neg_term));
    proportional_ctrl_in_n <= ~prop_on;
  end
endmodule // tlms_host_model

// [tb/tb_top.sv]
// self-checking bench for the torque limit and mode select block
`timescale 1ns/1ps
module tb_top;
  import tlms_pkg::*;
  logic core_clk = 1'b0;
  logic rst = 1'b1;
  logic [5:0] avs_address = 6'h00;
  logic avs_read = 1'b0;
  logic avs_write = 1'b0;
  logic [31:0] avs_writedata = 32'h0;
  logic [31:0] avs_readdata, q;
  logic avs_waitrequest, irq, proportional_ctrl_in_n;
  logic [7:0] term_in_n, term_out_n;
  logic signed [15:0] torque_ref_in = 16'sh0000;
  logic signed [15:0] torque_demand = 16'sh0000;
  logic signed [15:0] torque_out;
  tlms_mode_t active_mode;
  logic [1:0] int_speed_sel;
  logic pos_limit_alias, neg_limit_alias, torque_limiting_out_n;
  logic pos_on = 1'b0;
  logic neg_on = 1'b0;
  logic prop_on = 1'b0;
  logic [2:0] pos_term = 3'h0;
  logic [2:0] neg_term = 3'h1;
  int errors = 0;
  int compares = 0;
  int i;
  localparam logic signed [15:0] LIM_E = RST_EXT_LIM;
  localparam logic signed [15:0] LIM_I = RST_INT_LIM;
  tlms_mode_t pair[3] = '{TLMS_SPEED, TLMS_POSITION, TLMS_TORQUE};
  tlms_mode_t first[5] = '{TLMS_POSITION, TLMS_POSITION, TLMS_TORQUE, TLMS_SPEED, TLMS_POSITION};
  tlms_mode_t second[5] = '{TLMS_SPEED, TLMS_TORQUE, TLMS_SPEED, TLMS_ZERO_CLAMP,
    TLMS_POS_INHIBIT};
  logic [5:0] ofs[10] = '{OFS_CTRL, OFS_FWD_INT, OFS_REV_INT, OFS_POS_EXT, OFS_NEG_EXT,
    OFS_TREF_GAIN, OFS_IN_ASSIGN, OFS_OUT_ASSIGN, OFS_INT_STAT, OFS_INT_MASK};
  logic [31:0] rv[10] = '{32'(RST_CODE), 32'(RST_INT_LIM), 32'(RST_INT_LIM), 32'(RST_EXT_LIM),
    32'(RST_EXT_LIM), 32'(RST_GAIN), 32'h0, 32'h0, 32'h0, 32'h0};

  always #5 core_clk = ~core_clk;

  tlms_core uut (.core_clk(core_clk), .rst(rst), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
    .avs_byteenable(4'hf), .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
    .irq(irq), .term_in_n(term_in_n), .proportional_ctrl_in_n(proportional_ctrl_in_n),
    .term_out_n(term_out_n), .torque_ref_in(torque_ref_in), .torque_demand(torque_demand),
    .torque_out(torque_out), .active_mode(active_mode), .int_speed_sel(int_speed_sel),
    .pos_limit_alias(pos_limit_alias), .neg_limit_alias(neg_limit_alias),
    .torque_limiting_out_n(torque_limiting_out_n));

  tlms_host_model host (.core_clk(core_clk), .pos_on(pos_on), .neg_on(neg_on),
    .prop_on(prop_on), .pos_term(pos_term), .neg_term(neg_term), .term_in_n(term_in_n),
    .proportional_ctrl_in_n(proportional_ctrl_in_n));

  task automatic finish_test();
    $display("comparisons %0d mismatches %0d", compares, errors);
    if (errors == 0 && compares > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  task automatic chk_reg(input logic [31:0] g, input logic [31:0] e);
    compares++;
    if (g !== e) begin
      errors++;
      $display("Error at %0t: got %0h expected %0h", $time, g, e);
    end
  endtask

  task automatic chk_pin(input logic [15:0] g, input logic [15:0] e);
    chk_reg({16'h0, g}, {16'h0, e});
  endtask

  // called just after an edge; holds the request until waitrequest is seen low
  task automatic bus(input logic wr, input logic [5:0] a, input logic [31:0] d,
    output logic [31:0] r);
    avs_address <= a;
    avs_writedata <= d;
    avs_write <= wr;
    avs_read <= !wr;
    do begin
      @(posedge core_clk);
    end while (avs_waitrequest !== 1'b0);
    r = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
    @(posedge core_clk);
  endtask

  task automatic wr(input logic [5:0] a, input logic [31:0] d);
    logic [31:0] r;
    bus(1'b1, a, d, r);
  endtask

  // the host model and the core each add one register stage, so wait past both
  task automatic apply(input logic p, input logic n, input logic c,
    input logic signed [15:0] d, input logic signed [15:0] r);
    pos_on <= p;
    neg_on <= n;
    prop_on <= c;
    torque_demand <= d;
    torque_ref_in <= r;
    repeat (4) @(posedge core_clk);
  endtask

  initial begin
    repeat (20000) @(posedge core_clk);
    errors++;
    finish_test();
  end

  initial begin
    repeat (5) @(posedge core_clk);
    rst <= 1'b0;
    @(posedge core_clk);
    for (i = 0; i < 10; i++) begin
      bus(1'b0, ofs[i], 32'h0, q);
      chk_reg(q, rv[i]);
    end
    wr(6'h2c, 32'h0000ffff);
    bus(1'b0, 6'h2c, 32'h0, q);
    chk_reg(q, 32'h0);
    $display("test registers done");
    apply(1'b1, 1'b0, 1'b0, 16'sd200, 16'sd0);
    chk_pin(torque_out, LIM_E);
    chk_pin(16'(torque_limiting_out_n), 16'h0000);
    chk_pin(16'(term_out_n), 16'h00ff);
    bus(1'b0, OFS_STATUS, 32'h0, q);
    chk_reg(q, (32'h1 << ST_POS_ON_BIT) | (32'h1 << ST_CLAMP_BIT));
    apply(1'b0, 1'b0, 1'b0, 16'sd400, 16'sd0);
    chk_pin(torque_out, LIM_I);
    apply(1'b0, 1'b0, 1'b0, 16'sd200, 16'sd0);
    chk_pin(torque_out, 16'sd200);
    chk_pin(16'(torque_limiting_out_n), 16'h0001);
    apply(1'b0, 1'b1, 1'b0, -16'sd200, 16'sd0);
    chk_pin(torque_out, -LIM_E);
    apply(1'b1, 1'b0, 1'b0, -16'sd400, 16'sd0);
    chk_pin(torque_out, -LIM_I);
    wr(OFS_OUT_ASSIGN, 32'h0000000b);
    apply(1'b1, 1'b0, 1'b0, 16'sd200, 16'sd0);
    chk_pin(16'(term_out_n), 16'h00f7);
    $display("test limits done");
    wr(OFS_CTRL, 32'h00000010);
    apply(1'b1, 1'b0, 1'b0, 16'sd200, 16'sd0);
    chk_pin(torque_out, 16'sd200);
    wr(OFS_IN_ASSIGN, 32'h0000000a);
    pos_term <= 3'h2;
    apply(1'b1, 1'b0, 1'b0, 16'sd200, 16'sd0);
    chk_pin(torque_out, LIM_E);
    wr(OFS_IN_ASSIGN, 32'h000000aa);
    apply(1'b1, 1'b0, 1'b0, -16'sd200, 16'sd0);
    chk_pin(torque_out, -LIM_E);
    chk_pin(16'(neg_limit_alias), 16'h0001);
    chk_pin(16'(pos_limit_alias), 16'h0001);
    wr(OFS_IN_ASSIGN, 32'h0);
    pos_term <= 3'h0;
    wr(OFS_CTRL, 32'h00000020);
    apply(1'b1, 1'b0, 1'b0, 16'sd200, 16'sd150);
    chk_pin(torque_out, LIM_E);
    apply(1'b1, 1'b0, 1'b0, 16'sd200, 16'sd60);
    chk_pin(torque_out, 16'sd60);
    wr(OFS_CTRL, 32'h0);
    $display("test terminals done");
    apply(1'b0, 1'b0, 1'b0, 16'sd200, 16'sd0);
    wr(OFS_INT_STAT, 32'h3);
    wr(OFS_INT_MASK, 32'h1);
    chk_pin(16'(irq), 16'h0000);
    apply(1'b1, 1'b0, 1'b0, 16'sd200, 16'sd0);
    chk_pin(16'(irq), 16'h0001);
    wr(OFS_INT_STAT, 32'h1);
    chk_pin(16'(irq), 16'h0000);
    wr(OFS_INT_MASK, 32'h0);
    apply(1'b0, 1'b0, 1'b0, 16'sd200, 16'sd0);
    apply(1'b1, 1'b0, 1'b0, 16'sd200, 16'sd0);
    chk_pin(16'(irq), 16'h0000);
    bus(1'b0, OFS_INT_STAT, 32'h0, q);
    chk_pin(16'(q[0]), 16'h0001);
    $display("test interrupt done");
    for (i = 0; i < 3; i++) begin
      wr(OFS_CTRL, 32'(CODE_ISPD_SPD) + 32'(i));
      apply(1'b0, 1'b0, 1'b0, 16'sd200, 16'sd0);
      chk_pin(16'(active_mode), 16'(pair[i]));
      apply(1'b1, 1'b0, 1'b0, 16'sd200, 16'sd0);
      chk_pin(16'(active_mode), 16'(TLMS_INT_SPEED));
      chk_pin(torque_out, 16'sd200);
      chk_pin(16'(int_speed_sel), 16'h0001);
      apply(1'b0, 1'b1, 1'b0, 16'sd200, 16'sd0);
      chk_pin(16'(int_speed_sel), 16'h0002);
    end
    for (i = 0; i < 5; i++) begin
      wr(OFS_CTRL, 32'(CODE_POS_SPD) + 32'(i));
      apply(1'b0, 1'b0, 1'b1, 16'sd200, 16'sd0);
      chk_pin(16'(active_mode), 16'(second[i]));
      apply(1'b0, 1'b0, 1'b0, 16'sd200, 16'sd0);
      chk_pin(16'(active_mode), 16'(first[i]));
    end
    $display("test modes done");
    wr(OFS_CTRL, 32'(CODE_ISPD_TRQ));
    wr(OFS_TREF_GAIN, 32'h00000200);
    apply(1'b0, 1'b0, 1'b0, 16'sd0, 16'sd50);
    chk_pin(torque_out, 16'sd100);
    $display("test gain done");
    finish_test();
  end
endmodule // tb_top
